//--- hbsp_port.sv
`timescale 1ns/1ps
module hbsp_port
  import hbsp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Backplane bus
  input  wire logic [17:0] i_bus_addr,
  input  wire logic [1:0]  i_bus_ctl,
  input  wire logic [15:0] i_bus_data,
  input  wire logic        i_bus_msyn,
  input  wire logic        i_bus_ssyn,
  input  wire logic        i_bus_bbsy,
  input  wire logic        i_bus_init,
  input  wire logic        i_bus_bg5,
  input  wire logic        i_bus_npg,
  input  wire logic [11:0] i_base_jumper,
  output logic [17:0]      o_bus_addr,
  output logic             o_bus_addr_oe_n,
  output logic [1:0]       o_bus_ctl,
  output logic [15:0]      o_bus_data,
  output logic             o_bus_data_oe_n,
  output logic             o_bus_msyn,
  output logic             o_bus_ssyn,
  output logic             o_bus_intr,
  output logic [3:0]       o_bus_br,
  output logic             o_bus_npr,
  output logic             o_bus_sack,
  output logic             o_bus_bbsy,
  // Local processor side
  input  wire logic        i_lp_l2h_wr,
  input  wire logic [15:0] i_lp_l2h_data,
  input  wire logic        i_lp_vec_wr,
  input  wire logic [7:0]  i_lp_vec_data,
  input  wire logic        i_lp_ie_wr,
  input  wire logic        i_lp_ie,
  input  wire logic        i_lp_host_irq,
  input  wire logic        i_lp_ptr_load,
  input  wire logic [17:0] i_lp_ptr_data,
  input  wire logic        i_dma_go,
  input  wire logic        i_dma_to_host,
  input  wire logic [15:0] i_dma_wdata,
  output logic [15:0]      o_h2l_data,
  output logic [7:0]       o_vector,
  output logic             o_ctrl_reinit,
  output logic             o_host_init_write_irq,
  output logic             o_host_poll_read_irq,
  output logic             o_host_exchange_write_irq,
  output logic [15:0]      o_dma_rdata,
  output logic             o_dma_done,
  output logic             o_dma_busy,
  output logic [17:0]      o_dma_ptr
);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  hbsp_access_t   acc;
  hbsp_slave_st_t sl_st_q;
  hbsp_irq_st_t   iq_st_q;
  hbsp_dma_st_t   dm_st_q;

  logic [15:0] host_to_local_exchange_q;
  logic [15:0] local_to_host_exchange_q;
  logic [7:0]  interrupt_vector_hold_q;
  logic        int_enable_q;
  logic        vector_request_q;
  logic        init_seen_q;
  logic        ssyn_q;
  logic        intr_q;
  logic [3:0]  br_q;
  logic        npr_q;
  logic        sack_q;
  logic        bbsy_q;
  logic        msyn_q;
  logic        dma_address_drive_enable_q;
  logic [1:0]  ctl_q;
  logic        to_host_q;
  logic [4:0]  deskew_q;
  logic [15:0] internal_data_bus_q;
  logic        data_oe_n_q;
  logic [15:0] dma_rdata_q;
  logic        done_q;
  logic        busy_q;
  logic        reinit_q;
  logic        ipw_q;
  logic        ipr_q;
  logic        saw_q;
  logic        sl_take;
  logic        sl_release;
  logic        iq_gate;
  logic        iq_release;
  logic        dm_start;
  logic        dm_release;
  logic        init_evt;
  logic [17:0] dma_addr;

  hbsp_addr_match u_match (
    .i_addr        (i_bus_addr),
    .i_ctl         (i_bus_ctl),
    .i_base_jumper (i_base_jumper),
    .o_acc         (acc)
  );

  hbsp_dma_addr u_dma_addr (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_load      (i_lp_ptr_load),
    .i_load_addr (i_lp_ptr_data),
    .i_inc       (dm_release),
    .o_addr      (dma_addr)
  );

  // Slave events; no slave answer while this end masters the bus
  assign sl_take    = (sl_st_q == SL_IDLE) && i_bus_msyn && acc.hit &&
                      (dm_st_q == DM_IDLE);
  assign sl_release = (sl_st_q == SL_ACK) && !i_bus_msyn;
  assign iq_gate    = (iq_st_q == IQ_REQ) && i_bus_bg5;
  assign iq_release = (iq_st_q == IQ_VEC) && i_bus_ssyn;
  assign dm_start   = (dm_st_q == DM_SACK) && !i_bus_bbsy && !i_bus_ssyn && !i_bus_npg;
  assign dm_release = (dm_st_q == DM_END) && !i_bus_ssyn;
  // Bus init counts once per assertion, like a port write
  assign init_evt   = (sl_take && acc.ip && acc.wr) || (i_bus_init && !init_seen_q);

  // Slave handshake: SSYN rises with data, falls only after MSYN goes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sl_st_q <= SL_IDLE;
      ssyn_q  <= 1'b0;
    end else if (sl_take) begin
      sl_st_q <= SL_ACK;
      ssyn_q  <= 1'b1;
    end else if (sl_release) begin
      sl_st_q <= SL_IDLE;
      ssyn_q  <= 1'b0;
    end
  end

  // Host-to-local exchange register, loaded from the bus lines; each write
  // replaces the last, so ring base low and then high reach the local side in order
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      host_to_local_exchange_q <= XCHG_RESET;
    end else if (sl_take && acc.sa && acc.wr) begin
      host_to_local_exchange_q <= i_bus_data;
    end
  end

  // Local-to-host exchange register, written only by the local side
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      local_to_host_exchange_q <= XCHG_RESET;
    end else if (i_lp_l2h_wr) begin
      local_to_host_exchange_q <= i_lp_l2h_data;
    end
  end

  // Local interrupt pulses for init writes, poll reads and exchange writes, plus reinit; an exchange read gives none
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ipw_q    <= 1'b0;
      ipr_q    <= 1'b0;
      saw_q    <= 1'b0;
      reinit_q <= 1'b0;
    end else begin
      ipw_q    <= sl_take && acc.ip && acc.wr;
      ipr_q    <= sl_take && acc.ip && !acc.wr;
      saw_q    <= sl_take && acc.sa && acc.wr;
      reinit_q <= init_evt;
    end
  end

  // Edge memory for bus init level
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      init_seen_q <= 1'b0;
    end else begin
      init_seen_q <= i_bus_init;
    end
  end

  // Vector and enable; both return to defaults on reinitialization
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      interrupt_vector_hold_q <= VEC_RESET;
      int_enable_q            <= 1'b0;
    end else if (init_evt) begin
      interrupt_vector_hold_q <= VEC_RESET;
      int_enable_q            <= 1'b0;
    end else begin
      if (i_lp_vec_wr) begin
        interrupt_vector_hold_q <= i_lp_vec_data;
      end
      if (i_lp_ie_wr) begin
        int_enable_q <= i_lp_ie;
      end
    end
  end

  // Pending vector request; a new request in the gating cycle wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      vector_request_q <= 1'b0;
    end else if (i_lp_host_irq && int_enable_q) begin
      vector_request_q <= 1'b1;
    end else if (iq_gate || init_evt) begin
      vector_request_q <= 1'b0;
    end
  end

  // Interrupt sequence: request at level 5, vector out on grant
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      iq_st_q <= IQ_IDLE;
      br_q    <= 4'h0;
      intr_q  <= 1'b0;
    end else begin
      unique case (iq_st_q)
        IQ_IDLE: begin
          if (vector_request_q) begin
            iq_st_q <= IQ_REQ;
            br_q    <= BR_LEVEL5;
          end
        end
        IQ_REQ: begin
          if (iq_gate) begin
            iq_st_q <= IQ_VEC;
            br_q    <= 4'h0;
            intr_q  <= 1'b1;
          end
        end
        IQ_VEC: begin
          if (iq_release) begin
            iq_st_q <= IQ_END;
            intr_q  <= 1'b0;
          end
        end
        IQ_END: begin
          if (!i_bus_ssyn) begin
            iq_st_q <= IQ_IDLE;
          end
        end
      endcase
    end
  end

  // DMA master: one request, one grant, one word, then the bus is freed
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dm_st_q                    <= DM_IDLE;
      npr_q                      <= 1'b0;
      sack_q                     <= 1'b0;
      bbsy_q                     <= 1'b0;
      msyn_q                     <= 1'b0;
      dma_address_drive_enable_q <= 1'b0;
      ctl_q                      <= CTL_DATI;
      to_host_q                  <= 1'b0;
      deskew_q                   <= 5'h00;
      busy_q                     <= 1'b0;
    end else begin
      unique case (dm_st_q)
        DM_IDLE: begin
          if (i_dma_go) begin
            dm_st_q   <= DM_NPR;
            busy_q    <= 1'b1;
            npr_q     <= 1'b1;
            to_host_q <= i_dma_to_host;
          end
        end
        DM_NPR: begin
          if (i_bus_npg) begin
            dm_st_q <= DM_SACK;
            npr_q   <= 1'b0;
            sack_q  <= 1'b1;
          end
        end
        DM_SACK: begin
          if (dm_start) begin
            dm_st_q                    <= DM_ADDR;
            sack_q                     <= 1'b0;
            bbsy_q                     <= 1'b1;
            dma_address_drive_enable_q <= 1'b1;
            ctl_q                      <= to_host_q ? CTL_DATO : CTL_DATI;
            deskew_q                   <= 5'h00;
          end
        end
        DM_ADDR: begin
          // Address settles on the lines before master sync rises
          if (deskew_q == 5'(DESKEW_CYC - 1)) begin
            dm_st_q <= DM_SYNC;
            msyn_q  <= 1'b1;
          end else begin
            deskew_q <= deskew_q + 5'h01;
          end
        end
        DM_SYNC: begin
          if (i_bus_ssyn) begin
            dm_st_q <= DM_END;
            msyn_q  <= 1'b0;
          end
        end
        DM_END: begin
          if (dm_release) begin
            dm_st_q                    <= DM_IDLE;
            busy_q                     <= 1'b0;
            bbsy_q                     <= 1'b0;
            dma_address_drive_enable_q <= 1'b0;
            ctl_q                      <= CTL_DATI;
          end
        end
        default: begin
          dm_st_q <= DM_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // Read data captured at slave answer; done marks the word finished
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dma_rdata_q <= 16'h0000;
      done_q      <= 1'b0;
    end else begin
      done_q <= dm_release;
      if (dm_st_q == DM_SYNC && i_bus_ssyn && !to_host_q) begin
        dma_rdata_q <= i_bus_data;
      end
    end
  end

  // Shared data buffer. The bus grants one user at a time, so the
  // priority order here only settles cases the bus never produces.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      internal_data_bus_q <= 16'h0000;
      data_oe_n_q         <= 1'b1;
    end else if (sl_take && !acc.wr) begin
      internal_data_bus_q <= acc.sa ? local_to_host_exchange_q : IP_READ_DATA;
      data_oe_n_q         <= 1'b0;
    end else if (iq_gate) begin
      internal_data_bus_q <= {7'h00, interrupt_vector_hold_q, 1'b0};
      data_oe_n_q         <= 1'b0;
    end else if (dm_start && to_host_q) begin
      internal_data_bus_q <= i_dma_wdata;
      data_oe_n_q         <= 1'b0;
    end else if (sl_release || iq_release || dm_release) begin
      data_oe_n_q         <= 1'b1;
    end
  end

  assign o_bus_addr                = dma_addr;
  assign o_bus_addr_oe_n           = !dma_address_drive_enable_q;
  assign o_bus_ctl                 = ctl_q;
  assign o_bus_data                = internal_data_bus_q;
  assign o_bus_data_oe_n           = data_oe_n_q;
  assign o_bus_msyn                = msyn_q;
  assign o_bus_ssyn                = ssyn_q;
  assign o_bus_intr                = intr_q;
  assign o_bus_br                  = br_q;
  assign o_bus_npr                 = npr_q;
  assign o_bus_sack                = sack_q;
  assign o_bus_bbsy                = bbsy_q;
  assign o_h2l_data                = host_to_local_exchange_q;
  assign o_vector                  = interrupt_vector_hold_q;
  assign o_ctrl_reinit             = reinit_q;
  assign o_host_init_write_irq     = ipw_q;
  assign o_host_poll_read_irq      = ipr_q;
  assign o_host_exchange_write_irq = saw_q;
  assign o_dma_rdata               = dma_rdata_q;
  assign o_dma_done                = done_q;
  assign o_dma_busy                = busy_q;
  assign o_dma_ptr                 = dma_addr;

  sequence s_port_take(bit ip, bit wr);
    (sl_st_q == SL_IDLE) && i_bus_msyn && acc.hit && dm_st_q == DM_IDLE &&
    acc.ip == ip && acc.wr == wr;
  endsequence

  chk_ssyn_needs_msyn : assert property ($rose(o_bus_ssyn) |-> $past(i_bus_msyn))
    else $error("SSYN rose without MSYN");

  chk_ssyn_holds_msyn : assert property (o_bus_ssyn && i_bus_msyn |=> o_bus_ssyn)
    else $error("SSYN dropped while MSYN still high");

  chk_data_release : assert property ($fell(o_bus_ssyn) && iq_st_q != IQ_VEC &&
    dm_st_q == DM_IDLE |-> o_bus_data_oe_n)
    else $error("data lines held after SSYN fell");

  chk_sa_write_load : assert property (s_port_take(1'b0, 1'b1) |=>
    o_h2l_data == $past(i_bus_data) && o_host_exchange_write_irq)
    else $error("exchange write did not load register");

  chk_sa_read_data : assert property (s_port_take(1'b0, 1'b0) |=>
    o_bus_ssyn && !o_bus_data_oe_n && o_bus_data == $past(local_to_host_exchange_q))
    else $error("exchange read returned wrong data");

  chk_ip_write_init : assert property (s_port_take(1'b1, 1'b1) |=>
    o_host_init_write_irq && o_ctrl_reinit ##1 !o_host_init_write_irq)
    else $error("init write did not reinitialize");

  chk_ip_read_poll : assert property (s_port_take(1'b1, 1'b0) |=>
    o_host_poll_read_irq && !o_host_init_write_irq)
    else $error("poll read did not signal local side");

  chk_vec_gating : assert property (o_bus_intr |->
    !o_bus_data_oe_n && o_bus_data == {7'h00, o_vector, 1'b0})
    else $error("interrupt raised without vector on data");

  chk_irq_enabled : assert property ($rose(vector_request_q) |-> $past(int_enable_q))
    else $error("host interrupt requested while disabled");

  chk_br_level : assert property (o_bus_br != 4'h0 |-> o_bus_br == BR_LEVEL5)
    else $error("request on wrong bus level");

  chk_addr_enable : assert property (!o_bus_addr_oe_n |->
    o_bus_bbsy && (dm_st_q inside {DM_ADDR, DM_SYNC, DM_END}))
    else $error("DMA address driven outside ownership");

  chk_one_word : assert property (o_dma_done |-> !o_bus_npr && !o_bus_bbsy &&
    o_bus_addr_oe_n)
    else $error("bus kept after one word");

  chk_deskew_msyn : assert property ($rose(o_bus_msyn) |->
    $past(dm_st_q) == DM_ADDR && !o_bus_addr_oe_n)
    else $error("master sync without address setup");

endmodule : hbsp_port

//--- hbsp_pkg.sv
package hbsp_pkg;

  // Clock and DMA address setup time before master sync
  localparam int CLK_MHZ    = 200;
  localparam int DESKEW_NS  = 75;
  localparam int DESKEW_CYC = (DESKEW_NS * CLK_MHZ + 999) / 1000;

  // Address map: I/O page top bits and word offset bit A1
  localparam logic [4:0] IO_PAGE_TOP = 5'h1F;
  localparam logic       IP_OFFSET   = 1'b0;
  localparam logic       SA_OFFSET   = 1'b1;

  // Reset values and fixed answers
  localparam logic [7:0]  VEC_RESET    = 8'h36;   // 154 octal, vector bits 8:1
  localparam logic [3:0]  BR_LEVEL5    = 4'h2;    // One-hot over BR7..BR4
  localparam logic [15:0] XCHG_RESET   = 16'h0000;
  localparam logic [15:0] IP_READ_DATA = 16'h0000;
  localparam logic [1:0]  CTL_DATI     = 2'h0;
  localparam logic [1:0]  CTL_DATO     = 2'h2;

  typedef enum logic [0:0] {
    SL_IDLE = 1'b0,
    SL_ACK  = 1'b1
  } hbsp_slave_st_t;

  typedef enum logic [1:0] {
    IQ_IDLE = 2'b00,
    IQ_REQ  = 2'b01,
    IQ_VEC  = 2'b10,
    IQ_END  = 2'b11
  } hbsp_irq_st_t;

  typedef enum logic [2:0] {
    DM_IDLE = 3'b000,
    DM_NPR  = 3'b001,
    DM_SACK = 3'b010,
    DM_ADDR = 3'b011,
    DM_SYNC = 3'b100,
    DM_END  = 3'b101
  } hbsp_dma_st_t;

  // Decoded slave access
  typedef struct packed {
    logic hit;
    logic ip;
    logic sa;
    logic wr;
  } hbsp_access_t;

endpackage : hbsp_pkg

//--- hbsp_addr_match.sv
`timescale 1ns/1ps
module hbsp_addr_match
  import hbsp_pkg::*;
(
  input  wire logic [17:0] i_addr,
  input  wire logic [1:0]  i_ctl,
  input  wire logic [11:0] i_base_jumper,
  output hbsp_access_t     o_acc
);

  logic port_address_match;

  // Base covers A13:A2; A1 picks the port, A0 ignored for word access
  assign port_address_match = (i_addr[17:13] == IO_PAGE_TOP) &&
                              (i_addr[13:2] == i_base_jumper);

  // C1 alone gives direction; C0 byte flag is not used by these ports
  assign o_acc.hit = port_address_match;
  assign o_acc.ip  = port_address_match && (i_addr[1] == IP_OFFSET);
  assign o_acc.sa  = port_address_match && (i_addr[1] == SA_OFFSET);
  assign o_acc.wr  = i_ctl[1];

endmodule : hbsp_addr_match

//--- hbsp_dma_addr.sv
`timescale 1ns/1ps
module hbsp_dma_addr
  import hbsp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_load,
  input  wire logic [17:0] i_load_addr,
  input  wire logic        i_inc,
  output logic [17:0]      o_addr
);

  logic [15:0] dma_word_address_q;
  logic [1:0]  dma_address_extension_q;
  logic [16:0] sum;

  // Word step; carry out of bit 15 feeds the extension
  assign sum = {1'b0, dma_word_address_q} + 17'h0_0002;

  // Pointer and extension counters, load wins over increment
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dma_word_address_q      <= 16'h0000;
      dma_address_extension_q <= 2'h0;
    end else if (i_load) begin
      dma_word_address_q      <= i_load_addr[15:0];
      dma_address_extension_q <= i_load_addr[17:16];
    end else if (i_inc) begin
      dma_word_address_q      <= sum[15:0];
      dma_address_extension_q <= dma_address_extension_q + {1'b0, sum[16]};
    end
  end

  assign o_addr = {dma_address_extension_q, dma_word_address_q};

  chk_ext_carry_up : assert property (@(posedge i_clk) disable iff (i_rst)
    ($past(i_inc) && !$past(i_load) && $past(dma_word_address_q[15:1]) == 15'h7FFF)
    |-> dma_address_extension_q == $past(dma_address_extension_q) + 2'h1)
    else $error("extension did not step on boundary crossing");

endmodule : hbsp_dma_addr

//--- hbsp_host_model.sv
`timescale 1ns/1ps
module hbsp_host_model (
  input  wire logic        i_clk,
  input  wire logic [17:0] i_addr,
  input  wire logic [15:0] i_data,
  input  wire logic        i_ssyn,
  input  wire logic        i_msyn,
  input  wire logic        i_intr,
  input  wire logic [3:0]  i_br,
  input  wire logic        i_npr,
  input  wire logic [1:0]  i_dctl,
  output logic [17:0]      o_addr,
  output logic [1:0]       o_ctl,
  output logic [15:0]      o_data,
  output logic             o_msyn,
  output logic             o_ssyn,
  output logic             o_bg5,
  output logic             o_npg
);
  logic [15:0] last_vec;
  logic [17:0] dma_addr;
  logic [15:0] dma_data;
  initial begin
    {o_addr, o_ctl, o_data, o_msyn, o_ssyn, o_bg5, o_npg} = '0;
  end
  // Grants and slave answers trail the device by half a cycle
  always @(negedge i_clk) begin
    o_bg5  <= i_br[1];
    o_npg  <= i_npr;
    o_ssyn <= i_intr | i_msyn;
    if (i_intr) last_vec <= i_data;
    if (i_msyn) dma_addr <= i_addr;
    if (i_msyn) dma_data <= i_data;
    // Memory answers a device read with a fixed word
    if (i_msyn && !i_dctl[1]) o_data <= 16'hC35A;
  end
  // One slave cycle; lines show an inverted pattern once released
  task automatic cyc(input logic [17:0] a, input logic wr, input logic [15:0] d,
                     output logic [15:0] q, output logic ok);
    int n;
    @(negedge i_clk);
    o_addr = a;
    o_ctl  = wr ? 2'h2 : 2'h0;
    o_data = d;
    o_msyn = 1'b1;
    ok = 1'b0;
    n = 0;
    while (!ok && n < 20) begin
      @(posedge i_clk);
      n++;
      ok = (i_ssyn === 1'b1);
    end
    q = i_data;
    @(negedge i_clk);
    o_msyn = 1'b0;
    o_data = ~d;
    o_addr = ~a;
    n = 0;
    while (i_ssyn !== 1'b0 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
  endtask : cyc
endmodule : hbsp_host_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  import hbsp_pkg::*;
  localparam logic [17:0] BASE = {4'hF, 12'hD1A, 2'b00};
  logic        i_clk = 0, i_rst = 1, ok, done, binit = 0, to_h = 1;
  logic [15:0] rdata;
  logic [1:0]  d_ctl;
  logic        l2h_wr = 0, vec_wr = 0, ie_wr = 0, ie = 0, irq = 0, ld = 0, go = 0;
  logic [15:0] l2h = '0, q, h2l, d_data, h_data, bus_data;
  logic [7:0]  vec = '0, vreg, fails = 0, checked = 0, n_iw = 0, n_pr = 0, n_xw = 0, n_re = 0;
  logic [17:0] ptr = '0, d_addr, h_addr, bus_addr, d_ptr;
  logic        d_aoe_n, d_doe_n, d_msyn, d_ssyn, d_intr, d_npr, h_msyn, h_ssyn, h_bg5, h_npg;
  logic        iw, pr, xw, re;
  logic [1:0]  h_ctl;
  logic [3:0]  d_br;
  always #2.5 i_clk = ~i_clk;
  // Shared lines follow whichever side has its drivers on
  assign bus_addr = !d_aoe_n ? d_addr : h_addr;
  assign bus_data = !d_doe_n ? d_data : h_data;
  hbsp_port i_hbsp_port (.i_clk(i_clk), .i_rst(i_rst), .i_bus_addr(bus_addr),
    .i_bus_ctl(h_ctl), .i_bus_data(bus_data), .i_bus_msyn(h_msyn), .i_bus_ssyn(h_ssyn),
    .i_bus_bbsy(1'b0), .i_bus_init(binit), .i_bus_bg5(h_bg5), .i_bus_npg(h_npg),
    .i_base_jumper(12'hD1A), .o_bus_addr(d_addr), .o_bus_addr_oe_n(d_aoe_n), .o_bus_ctl(d_ctl),
    .o_bus_data(d_data), .o_bus_data_oe_n(d_doe_n), .o_bus_msyn(d_msyn), .o_bus_ssyn(d_ssyn),
    .o_bus_intr(d_intr), .o_bus_br(d_br), .o_bus_npr(d_npr), .o_bus_sack(), .o_bus_bbsy(),
    .i_lp_l2h_wr(l2h_wr), .i_lp_l2h_data(l2h), .i_lp_vec_wr(vec_wr), .i_lp_vec_data(vec),
    .i_lp_ie_wr(ie_wr), .i_lp_ie(ie), .i_lp_host_irq(irq), .i_lp_ptr_load(ld),
    .i_lp_ptr_data(ptr), .i_dma_go(go), .i_dma_to_host(to_h), .i_dma_wdata(16'h5A3C),
    .o_h2l_data(h2l), .o_vector(vreg), .o_ctrl_reinit(re), .o_host_init_write_irq(iw),
    .o_host_poll_read_irq(pr), .o_host_exchange_write_irq(xw), .o_dma_rdata(rdata),
    .o_dma_done(done), .o_dma_busy(), .o_dma_ptr(d_ptr));
  hbsp_host_model i_hbsp_host_model (.i_clk(i_clk), .i_addr(bus_addr), .i_data(bus_data),
    .i_ssyn(d_ssyn), .i_msyn(d_msyn), .i_intr(d_intr), .i_br(d_br), .i_npr(d_npr), .i_dctl(d_ctl),
    .o_addr(h_addr), .o_ctl(h_ctl), .o_data(h_data), .o_msyn(h_msyn), .o_ssyn(h_ssyn),
    .o_bg5(h_bg5), .o_npg(h_npg));
  // Pulses are counted so a missing or doubled one shows
  always @(posedge i_clk) begin
    n_iw <= n_iw + 8'(iw);
    n_pr <= n_pr + 8'(pr);
    n_xw <= n_xw + 8'(xw);
    n_re <= n_re + 8'(re);
  end
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic pulse(ref logic s);
    @(negedge i_clk) s = 1'b1;
    @(negedge i_clk) s = 1'b0;
  endtask : pulse
  task automatic report_and_stop;
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #10000;
    fails++;
    report_and_stop;
  end
  initial begin
    repeat (4) @(posedge i_clk);
    @(negedge i_clk) i_rst = 1'b0;
    check(vreg, 8'h36);
    i_hbsp_host_model.cyc(BASE | 18'h2, 1'b1, 16'hA5C3, q, ok);
    check(ok, 1);
    check(h2l, 16'hA5C3);
    check(n_xw, 1);
    // Ring base low, then high, as the local side expects them
    i_hbsp_host_model.cyc(BASE | 18'h2, 1'b1, 16'h4C00, q, ok);
    check(h2l, 16'h4C00);
    i_hbsp_host_model.cyc(BASE | 18'h2, 1'b1, 16'h0003, q, ok);
    check(h2l, 16'h0003);
    check(n_xw, 3);
    l2h = 16'h3C96;
    pulse(l2h_wr);
    i_hbsp_host_model.cyc(BASE | 18'h2, 1'b0, 16'h0000, q, ok);
    check(q, 16'h3C96);
    i_hbsp_host_model.cyc(BASE, 1'b1, 16'h1234, q, ok);
    check(n_iw, 1);
    check(n_re, 1);
    i_hbsp_host_model.cyc(BASE, 1'b0, 16'hFFFF, q, ok);
    check(q, 16'h0000);
    check(n_pr, 1);
    i_hbsp_host_model.cyc(BASE + 18'h4, 1'b1, 16'h1111, q, ok);
    check(ok, 0);
    $display("port access test done");
    pulse(irq);
    repeat (5) @(negedge i_clk);
    check(d_br, 0);
    ie = 1'b1;
    pulse(ie_wr);
    vec = 8'hFE;
    pulse(vec_wr);
    pulse(irq);
    repeat (20) @(negedge i_clk);
    check(i_hbsp_host_model.last_vec, 16'h01FC);
    // A held bus init level gives one reinit and restores the vector
    binit = 1'b1;
    repeat (3) @(negedge i_clk);
    binit = 1'b0;
    @(negedge i_clk);
    check(n_re, 2);
    check(vreg, 8'h36);
    $display("interrupt test done");
    ptr = 18'h0FFFE;
    pulse(ld);
    pulse(go);
    repeat (100) if (!done) @(posedge i_clk);
    check(i_hbsp_host_model.dma_addr, 18'h0FFFE);
    check(i_hbsp_host_model.dma_data, 16'h5A3C);
    check(d_ptr, 18'h10000);
    // Second word reads from host memory at the stepped pointer
    @(negedge i_clk) to_h = 1'b0;
    pulse(go);
    repeat (100) if (!done) @(posedge i_clk);
    check(i_hbsp_host_model.dma_addr, 18'h10000);
    check(rdata, 16'hC35A);
    check(d_ptr, 18'h10002);
    $display("dma test done");
    report_and_stop;
  end
endmodule : testbench
